// file: pow_defines.vh
/*
 * Register offsets, field positions and reset values for the PCIe
 * outbound window and wake logic. Assumes byte addresses on a 32-bit
 * AXI4-Lite register bus, one aligned word per register.
 */
`ifndef POW_DEFINES_VH
`define POW_DEFINES_VH

`define POW_ADDR_W          8
`define POW_OFS_PM_STATUS   8'h08
`define POW_OFS_DMA_WIN     8'h28
`define POW_OFS_BM_WIN      8'h2C
`define POW_OFS_WAKE_CFG    8'h30
`define POW_OFS_EVENTS      8'h38
`define POW_OFS_EVENT_ENA   8'h3C
`define POW_OFS_EVENT_ACT   8'h40

`define POW_WIN_UPPER_MSB   1
`define POW_WIN_UPPER_LSB   0
`define POW_WIN_BASE        2'h3
`define POW_BE_MSB          27
`define POW_BE_LSB          24
`define POW_MSG_MSB         22
`define POW_MSG_LSB         15
`define POW_TC_MSB          14
`define POW_TC_LSB          12
`define POW_EP_BIT          8
`define POW_WAKE_POLARITY_BIT    2
`define POW_WAKE_OE_BIT     1
`define POW_BEACON_DISABLE_BIT  0
`define POW_PM_EVENT_BIT    0

`define POW_RST_DMA_WIN     32'h0000_0000
`define POW_RST_BM_WIN      32'h0000_0000
`define POW_RST_WAKE_CFG    32'h0000_0000
`define POW_RST_EVENTS      1'b0
`define POW_RST_POWER_MGMT_STATE    3'h0

`define POW_RESP_OKAY       2'h0
`define POW_RESP_SLVERR     2'h2

`endif

// file: pow_axil_slave.v
/*
 * AXI4-Lite slave front end: accepts write address and data in either
 * order, issues one write strobe, then a response; issues one read
 * strobe and registers the returned data. Assumes the register file
 * answers reads combinationally from the strobe address.
 */
`include "pow_defines.vh"
module pow_axil_slave (
  input  wire                   clk_i,
  input  wire                   rst_n_i,
  input  wire [31:0]            awaddr_i,
  input  wire                   awvalid_i,
  output reg                    awready_o,
  input  wire [31:0]            wdata_i,
  input  wire [3:0]             wstrb_i,
  input  wire                   wvalid_i,
  output reg                    wready_o,
  output reg  [1:0]             bresp_o,
  output reg                    bvalid_o,
  input  wire                   bready_i,
  input  wire [31:0]            araddr_i,
  input  wire                   arvalid_i,
  output reg                    arready_o,
  output reg  [31:0]            rdata_o,
  output reg  [1:0]             rresp_o,
  output reg                    rvalid_o,
  input  wire                   rready_i,
  output wire                   wr_req_o,
  output wire [`POW_ADDR_W-1:0] wr_addr_o,
  output wire [31:0]            wr_data_o,
  output wire [3:0]             wr_strb_o,
  input  wire                   wr_ok_i,
  output wire                   rd_req_o,
  output wire [`POW_ADDR_W-1:0] rd_addr_o,
  input  wire [31:0]            rd_data_i,
  input  wire                   rd_ok_i
);
  reg                   aw_held;
  reg                   w_held;
  reg [`POW_ADDR_W-1:0] aw_addr;
  reg [31:0]            w_data;
  reg [3:0]             w_strb;
  wire                  aw_take = awvalid_i & awready_o;
  wire                  w_take  = wvalid_i & wready_o;
  wire                  next_aw_held;
  wire                  next_w_held;
  wire                  next_bvalid;

  // Write fires once both halves are held and no response is pending
  assign wr_req_o     = aw_held & w_held & ~bvalid_o;
  assign wr_addr_o    = aw_addr;
  assign wr_data_o    = w_data;
  assign wr_strb_o    = w_strb;
  assign next_aw_held = (aw_held | aw_take) & ~wr_req_o;
  assign next_w_held  = (w_held | w_take) & ~wr_req_o;
  assign next_bvalid  = wr_req_o | (bvalid_o & ~bready_i);

  assign rd_req_o  = arvalid_i & arready_o;
  assign rd_addr_o = araddr_i[`POW_ADDR_W-1:0];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= {`POW_ADDR_W{1'b0}};
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `POW_RESP_OKAY;
      arready_o <= 1'b0;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= `POW_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr <= awaddr_i[`POW_ADDR_W-1:0];
      end
      if (w_take) begin
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      awready_o <= ~next_aw_held & ~next_bvalid;
      wready_o  <= ~next_w_held & ~next_bvalid;
      bvalid_o  <= next_bvalid;
      if (wr_req_o) begin
        bresp_o <= wr_ok_i ? `POW_RESP_OKAY : `POW_RESP_SLVERR;
      end
      if (rd_req_o) begin
        rvalid_o  <= 1'b1;
        rdata_o   <= rd_ok_i ? rd_data_i : 32'h0000_0000;
        rresp_o   <= rd_ok_i ? `POW_RESP_OKAY : `POW_RESP_SLVERR;
        arready_o <= 1'b0;
      end else if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end else begin
        arready_o <= ~rvalid_o;
      end
    end
  end
endmodule // pow_axil_slave

// file: pow_window_map.v
/*
 * One outbound 1 GByte window: detects an access in the top quarter of
 * the internal address map and swaps bits 31:30 for the programmed
 * upper bits. Combinational; the caller registers the result.
 */
`include "pow_defines.vh"
module pow_window_map (
  input  wire [31:0] addr_i,
  input  wire        valid_i,
  input  wire [1:0]  upper_i,
  output wire        hit_o,
  output wire [31:0] addr_o
);
  // Window is 0xC0000000 to 0xFFFFFFFF
  assign hit_o  = valid_i & (addr_i[31:30] == `POW_WIN_BASE);
  assign addr_o = {upper_i, addr_i[29:0]};
endmodule // pow_window_map

// file: pow_outbound_wake.v
/*
 * PCIe outbound address windows, shared-bus header fields, wake and
 * beacon control, power-state change event with interrupt. Assumes all
 * inputs come from logic on CLK_I and a synchronous active-low reset.
 */
`include "pow_defines.vh"
module pow_outbound_wake (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  input  wire [31:0] S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output wire        S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output wire        S_AXI_WREADY_O,
  output wire [1:0]  S_AXI_BRESP_O,
  output wire        S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [31:0] S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output wire        S_AXI_ARREADY_O,
  output wire [31:0] S_AXI_RDATA_O,
  output wire [1:0]  S_AXI_RRESP_O,
  output wire        S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  input  wire [31:0] DMA_ADDR_I,
  input  wire        DMA_VALID_I,
  output reg         DMA_PCIE_HIT_O,
  output reg  [31:0] DMA_PCIE_ADDR_O,
  input  wire [31:0] SB_ADDR_I,
  input  wire        SB_VALID_I,
  input  wire        SB_MEM_I,
  input  wire [3:0]  SB_BE_I,
  output reg         SB_PCIE_HIT_O,
  output reg  [31:0] SB_PCIE_ADDR_O,
  output reg  [3:0]  SB_PCIE_BE_O,
  output reg  [7:0]  SB_PCIE_MSG_CODE_O,
  output reg  [2:0]  SB_PCIE_TC_O,
  output reg         SB_PCIE_POISON_O,
  input  wire        WAKE_REQ_I,
  output reg         WAKE_O,
  output reg         WAKE_OE_O,
  input  wire        BEACON_REQ_I,
  output reg         BEACON_O,
  input  wire [2:0]  POWER_MGMT_STATE_I,
  output reg         IRQ_O
);
  reg  [31:0]            dma_pcie_window;
  reg  [31:0]            bus_master_pcie_window;
  reg  [31:0]            link_wake_config;
  reg                    power_state_change_event;
  reg                    power_state_event_enable;
  reg  [2:0]             power_mgmt_state;
  reg  [2:0]             power_mgmt_state_prev;
  wire                   wr_req;
  wire [`POW_ADDR_W-1:0] wr_addr;
  wire [31:0]            wr_data;
  wire [3:0]             wr_strb;
  wire                   rd_req;
  wire [`POW_ADDR_W-1:0] rd_addr;
  reg  [31:0]            rd_data;
  reg                    rd_ok;
  reg                    wr_ok;
  wire [31:0]            wr_mask;
  wire                   dma_hit;
  wire [31:0]            dma_addr;
  wire                   sb_hit;
  wire [31:0]            sb_addr;
  wire                   pm_change;
  wire                   event_clear;
  wire                   event_active;
  wire                   dma_window_upper_bits_dummy;
  wire [1:0]             dma_window_upper_bits;
  wire [1:0]             bus_master_window_upper_bits;
  wire [3:0]             outbound_byte_enable;
  wire [7:0]             outbound_message_code;
  wire [2:0]             outbound_traffic_class;
  wire                   outbound_poisoned_flag;
  wire                   wake_polarity;
  wire                   wake_always_drive;
  wire                   beacon_disable;

  assign dma_window_upper_bits_dummy = 1'b0;
  assign dma_window_upper_bits =
    dma_pcie_window[`POW_WIN_UPPER_MSB:`POW_WIN_UPPER_LSB];
  assign bus_master_window_upper_bits =
    bus_master_pcie_window[`POW_WIN_UPPER_MSB:`POW_WIN_UPPER_LSB];
  assign outbound_byte_enable =
    bus_master_pcie_window[`POW_BE_MSB:`POW_BE_LSB];
  assign outbound_message_code =
    bus_master_pcie_window[`POW_MSG_MSB:`POW_MSG_LSB];
  assign outbound_traffic_class =
    bus_master_pcie_window[`POW_TC_MSB:`POW_TC_LSB];
  assign outbound_poisoned_flag = bus_master_pcie_window[`POW_EP_BIT];
  assign wake_polarity     = link_wake_config[`POW_WAKE_POLARITY_BIT];
  assign wake_always_drive = link_wake_config[`POW_WAKE_OE_BIT];
  assign beacon_disable    = link_wake_config[`POW_BEACON_DISABLE_BIT];

  pow_axil_slave u_bus (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .wr_req_o  (wr_req),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_ok_i   (wr_ok),
    .rd_req_o  (rd_req),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_ok_i   (rd_ok)
  );

  pow_window_map u_dma_win (
    .addr_i  (DMA_ADDR_I),
    .valid_i (DMA_VALID_I),
    .upper_i (dma_window_upper_bits),
    .hit_o   (dma_hit),
    .addr_o  (dma_addr)
  );

  pow_window_map u_sb_win (
    .addr_i  (SB_ADDR_I),
    .valid_i (SB_VALID_I),
    .upper_i (bus_master_window_upper_bits),
    .hit_o   (sb_hit),
    .addr_o  (sb_addr)
  );

  // Byte-lane write mask from strobes
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_mask
      assign wr_mask[8*g+7:8*g] = {8{wr_strb[g]}};
    end
  endgenerate

  assign pm_change    = (POWER_MGMT_STATE_I != power_mgmt_state_prev);
  assign event_clear  = wr_req & (wr_addr == `POW_OFS_EVENTS) &
                        wr_strb[0] & wr_data[`POW_PM_EVENT_BIT];
  assign event_active = power_state_change_event &
                        power_state_event_enable;

  // Address decode for writes
  always @* begin
    case (wr_addr)
      `POW_OFS_DMA_WIN,
      `POW_OFS_BM_WIN,
      `POW_OFS_WAKE_CFG,
      `POW_OFS_EVENTS,
      `POW_OFS_EVENT_ENA:  wr_ok = 1'b1;
      default:             wr_ok = 1'b0;
    endcase
  end

  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      `POW_OFS_PM_STATUS: rd_data[2:0] = power_mgmt_state;
      `POW_OFS_DMA_WIN:   rd_data = dma_pcie_window;
      `POW_OFS_BM_WIN:    rd_data = bus_master_pcie_window;
      `POW_OFS_WAKE_CFG:  rd_data = link_wake_config;
      `POW_OFS_EVENTS:    rd_data[0] = power_state_change_event;
      `POW_OFS_EVENT_ENA: rd_data[0] = power_state_event_enable;
      `POW_OFS_EVENT_ACT: rd_data[0] = event_active;
      default:            rd_ok = 1'b0;
    endcase
  end

  // Register file
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dma_pcie_window          <= `POW_RST_DMA_WIN;
      bus_master_pcie_window   <= `POW_RST_BM_WIN;
      link_wake_config         <= `POW_RST_WAKE_CFG;
      power_state_event_enable <= 1'b0;
    end else if (wr_req) begin
      case (wr_addr)
        `POW_OFS_DMA_WIN:
          dma_pcie_window <= (dma_pcie_window & ~wr_mask) |
                             (wr_data & wr_mask);
        `POW_OFS_BM_WIN:
          bus_master_pcie_window <= (bus_master_pcie_window & ~wr_mask) |
                                    (wr_data & wr_mask);
        `POW_OFS_WAKE_CFG:
          link_wake_config <= (link_wake_config & ~wr_mask) |
                              (wr_data & wr_mask);
        `POW_OFS_EVENT_ENA: begin
          if (wr_strb[0]) begin
            power_state_event_enable <= wr_data[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Power state tracking and sticky event; a new change beats a clear
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      power_mgmt_state         <= `POW_RST_POWER_MGMT_STATE;
      power_mgmt_state_prev            <= `POW_RST_POWER_MGMT_STATE;
      power_state_change_event <= `POW_RST_EVENTS;
      IRQ_O                    <= 1'b0;
    end else begin
      power_mgmt_state <= POWER_MGMT_STATE_I;
      power_mgmt_state_prev    <= POWER_MGMT_STATE_I;
      if (pm_change) begin
        power_state_change_event <= 1'b1;
      end else if (event_clear) begin
        power_state_change_event <= 1'b0;
      end
      IRQ_O <= event_active;
    end
  end

  // Outbound address and header fields
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DMA_PCIE_HIT_O     <= 1'b0;
      DMA_PCIE_ADDR_O    <= 32'h0000_0000;
      SB_PCIE_HIT_O      <= 1'b0;
      SB_PCIE_ADDR_O     <= 32'h0000_0000;
      SB_PCIE_BE_O       <= 4'h0;
      SB_PCIE_MSG_CODE_O <= 8'h00;
      SB_PCIE_TC_O       <= 3'h0;
      SB_PCIE_POISON_O   <= 1'b0;
    end else begin
      DMA_PCIE_HIT_O     <= dma_hit;
      DMA_PCIE_ADDR_O    <= dma_addr;
      SB_PCIE_HIT_O      <= sb_hit;
      SB_PCIE_ADDR_O     <= sb_addr;
      SB_PCIE_BE_O       <= SB_MEM_I ? SB_BE_I
                                     : outbound_byte_enable;
      SB_PCIE_MSG_CODE_O <= outbound_message_code;
      SB_PCIE_TC_O       <= outbound_traffic_class;
      SB_PCIE_POISON_O   <= outbound_poisoned_flag;
    end
  end

  // Wake pin and beacon
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      WAKE_O    <= 1'b1;
      WAKE_OE_O <= 1'b0;
      BEACON_O  <= 1'b0;
    end else begin
      WAKE_O    <= WAKE_REQ_I ? wake_polarity : ~wake_polarity;
      WAKE_OE_O <= wake_always_drive | WAKE_REQ_I;
      BEACON_O  <= BEACON_REQ_I & ~beacon_disable;
    end
  end
endmodule // pow_outbound_wake

// file: pow_outbound_wake_assertions.sv
/* Port checker for pow_outbound_wake: windows, header fields, wake,
   beacon and event interrupt. Assumes one clock and bind by name. */
module pow_outbound_wake_chk (
  input wire        CLK_I,
  input wire        RST_N_I,
  input wire [31:0] DMA_ADDR_I,
  input wire        DMA_VALID_I,
  input wire        DMA_PCIE_HIT_O,
  input wire [31:0] DMA_PCIE_ADDR_O,
  input wire [31:0] SB_ADDR_I,
  input wire        SB_VALID_I,
  input wire        SB_MEM_I,
  input wire [3:0]  SB_BE_I,
  input wire        SB_PCIE_HIT_O,
  input wire [31:0] SB_PCIE_ADDR_O,
  input wire [3:0]  SB_PCIE_BE_O,
  input wire [7:0]  SB_PCIE_MSG_CODE_O,
  input wire [2:0]  SB_PCIE_TC_O,
  input wire        SB_PCIE_POISON_O,
  input wire        S_AXI_BVALID_O,
  input wire        WAKE_REQ_I,
  input wire        WAKE_O,
  input wire        WAKE_OE_O,
  input wire        BEACON_REQ_I,
  input wire        BEACON_O,
  input wire        IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_dma_hit: assert property (
    DMA_VALID_I && &DMA_ADDR_I[31:30] |=> DMA_PCIE_HIT_O &&
    ((DMA_PCIE_ADDR_O ^ $past(DMA_ADDR_I)) & 32'h3FFFFFFF) == 32'h0)
    else $error("dma window hit wrong");
  chk_dma_miss: assert property (
    !(DMA_VALID_I && &DMA_ADDR_I[31:30]) |=> !DMA_PCIE_HIT_O)
    else $error("dma window false hit");
  chk_sb_hit: assert property (
    SB_VALID_I && &SB_ADDR_I[31:30] |=> SB_PCIE_HIT_O &&
    ((SB_PCIE_ADDR_O ^ $past(SB_ADDR_I)) & 32'h3FFFFFFF) == 32'h0)
    else $error("bus window hit wrong");
  chk_sb_miss: assert property (
    !(SB_VALID_I && &SB_ADDR_I[31:30]) |=> !SB_PCIE_HIT_O)
    else $error("bus window false hit");
  chk_mem_be: assert property (
    SB_MEM_I |=> SB_PCIE_BE_O == $past(SB_BE_I))
    else $error("memory byte enables not passed");
  chk_sb_fields: assert property (
    !$stable({SB_PCIE_MSG_CODE_O, SB_PCIE_TC_O, SB_PCIE_POISON_O})
    |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
    else $error("header fields changed without write");
  chk_irq_clear: assert property (
    $fell(IRQ_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
    else $error("interrupt dropped without write");
  chk_beacon_gate: assert property (
    !BEACON_REQ_I |=> !BEACON_O)
    else $error("beacon without request");
  chk_wake_drive: assert property (
    WAKE_REQ_I |=> WAKE_OE_O)
    else $error("wake asserted but not driven");
  chk_wake_flip: assert property (
    $changed(WAKE_REQ_I) |=> $changed(WAKE_O))
    else $error("wake level did not follow request");
  cover property (DMA_PCIE_HIT_O && SB_PCIE_HIT_O);
  cover property ($rose(IRQ_O));
  cover property (WAKE_REQ_I ##1 WAKE_OE_O);
endmodule // pow_outbound_wake_chk

bind pow_outbound_wake pow_outbound_wake_chk u_chk (.*);

// file: pow_core_model.sv
/* Behavioural PCIe core beside the block: power state and wake net.
   Assumes a pull-up on the wake net and calls right after an edge. */
module pow_core_model (
  input  wire       clk_i,
  input  wire       wake_i,
  input  wire       wake_oe_i,
  output reg  [2:0] power_mgmt_state_o,
  output wire       wake_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial power_mgmt_state_o = 3'h0;
  // Released net floats to the pull level
  assign wake_line_o = wake_oe_i ? wake_i : 1'b1;
  // State codes 0 to 7 move on an edge
  task automatic set_pm(input logic [2:0] v);
    @(posedge clk_i);
    power_mgmt_state_o <= v;
  endtask
endmodule // pow_core_model

// file: test_pcie_outbound_window_wake_cfg.sv
/* Self-checking bench for pow_outbound_wake.
   Assumes the bound checker and pow_core_model as the core. */
`include "pow_defines.vh"
module test_pcie_outbound_window_wake_cfg;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic v; logic [31:0] da, sa; logic m; logic [3:0] be;
    logic dh; logic [31:0] dx; logic sh; logic [31:0] sx; logic [3:0] bx;
  } pow_row_t;
  logic        CLK_I = 0, RST_N_I = 0, S_AXI_BREADY_I = 1, S_AXI_RREADY_I = 1;
  logic [31:0] S_AXI_AWADDR_I = '0, S_AXI_WDATA_I = '0, S_AXI_ARADDR_I = '0;
  logic [31:0] DMA_ADDR_I = 32'hC0000000, SB_ADDR_I = 32'hC0000000;
  logic [3:0]  S_AXI_WSTRB_I = 4'hF, SB_BE_I = '0;
  logic        S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_ARVALID_I = 0;
  logic        DMA_VALID_I = 0, SB_VALID_I = 0, SB_MEM_I = 0;
  logic        WAKE_REQ_I = 0, BEACON_REQ_I = 0, e;
  wire  [2:0]  POWER_MGMT_STATE_I, SB_PCIE_TC_O;
  wire         S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, IRQ_O;
  wire         S_AXI_ARREADY_O, S_AXI_RVALID_O, DMA_PCIE_HIT_O, WAKE_O;
  wire         SB_PCIE_HIT_O, SB_PCIE_POISON_O, WAKE_OE_O, BEACON_O, wake_line;
  wire  [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire  [31:0] S_AXI_RDATA_O, DMA_PCIE_ADDR_O, SB_PCIE_ADDR_O;
  wire  [3:0]  SB_PCIE_BE_O;
  wire  [7:0]  SB_PCIE_MSG_CODE_O;
  int          errors = 0, checks = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [7:0]  ra[7] = '{`POW_OFS_PM_STATUS, `POW_OFS_DMA_WIN,
    `POW_OFS_BM_WIN, `POW_OFS_WAKE_CFG, `POW_OFS_EVENTS,
    `POW_OFS_EVENT_ENA, `POW_OFS_EVENT_ACT};
  pow_row_t    rows[4] = '{
    '{1,32'hC0001234,32'hC0000010,0,4'hF,1,32'h40001234,1,32'h10,4'hA},
    '{1,32'hBFFFFFFC,32'hFFFFFFFF,1,4'h3,0,32'h7FFFFFFC,1,32'h3FFFFFFF,4'h3},
    '{1,32'hFFFFFFFF,32'h00000000,0,4'h0,1,32'h7FFFFFFF,0,32'h0,4'hA},
    '{0,32'hC0000000,32'hC0000000,1,4'h5,0,32'h40000000,0,32'h0,4'h5}};

  pow_outbound_wake uut (.*);
  pow_core_model core (.clk_i(CLK_I), .wake_i(WAKE_O), .wake_oe_i(WAKE_OE_O),
    .power_mgmt_state_o(POWER_MGMT_STATE_I), .wake_line_o(wake_line));

  always #5 CLK_I = ~CLK_I;

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    checks++;
    if (x !== g) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic hang(int n);
    if (n >= 100) begin
      errors++;
      $display("[FAIL] handshake expected 1 seen 0");
      wrap_up();
    end
  endtask
  // Write: both halves offered together, each dropped when taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    S_AXI_AWADDR_I <= {24'h0, a};
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY_O === 1'b1) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O === 1'b1) S_AXI_WVALID_I <= 1'b0;
      if (S_AXI_BVALID_O === 1'b1) break;
    end
    hang(n);
    rs = S_AXI_BRESP_O;
  endtask
  task automatic rdr(logic [7:0] a);
    int n;
    S_AXI_ARADDR_I <= {24'h0, a};
    S_AXI_ARVALID_I <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY_O === 1'b1) S_AXI_ARVALID_I <= 1'b0;
      if (S_AXI_RVALID_O === 1'b1) break;
    end
    hang(n);
    rd = S_AXI_RDATA_O;
    rs = S_AXI_RRESP_O;
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] x);
    rdr(a);
    cmp(n, x, rd);
  endtask

  initial begin
    repeat (5) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    foreach (ra[i]) rc("reset value", ra[i], 32'h0);
    rdr(8'h04);
    cmp("unmapped read", {`POW_RESP_SLVERR, 30'h0}, {rs, rd[29:0]});
    wr(8'h04, 32'hFFFFFFFF);
    cmp("unmapped write", `POW_RESP_SLVERR, rs);
    for (int u = 0; u < 4; u++) begin
      wr(`POW_OFS_DMA_WIN, u);
      wr(`POW_OFS_BM_WIN, 32'h0A2D5100 | (3 - u));
      @(posedge CLK_I);
      @(negedge CLK_I);
      cmp("dma upper", {u[1:0], 30'h0}, DMA_PCIE_ADDR_O);
      cmp("sb upper", {2'(3 - u), 30'h0}, SB_PCIE_ADDR_O);
      @(posedge CLK_I);
    end
    wr(`POW_OFS_DMA_WIN, 32'h1);
    rc("dma window", `POW_OFS_DMA_WIN, 32'h1);
    foreach (rows[i]) begin
      DMA_VALID_I <= rows[i].v;
      SB_VALID_I <= rows[i].v;
      DMA_ADDR_I <= rows[i].da;
      SB_ADDR_I <= rows[i].sa;
      SB_MEM_I <= rows[i].m;
      SB_BE_I <= rows[i].be;
      @(posedge CLK_I);
      @(negedge CLK_I);
      cmp("dma hit", rows[i].dh, DMA_PCIE_HIT_O);
      cmp("dma addr", rows[i].dx, DMA_PCIE_ADDR_O);
      cmp("sb hit", rows[i].sh, SB_PCIE_HIT_O);
      cmp("sb addr", rows[i].sx, SB_PCIE_ADDR_O);
      cmp("sb be", rows[i].bx, SB_PCIE_BE_O);
      @(posedge CLK_I);
    end
    cmp("msg code", 32'h5A, SB_PCIE_MSG_CODE_O);
    cmp("traffic class", 32'h5, SB_PCIE_TC_O);
    cmp("poison", 32'h1, SB_PCIE_POISON_O);
    // Power state codes, event, enable, clear
    wr(`POW_OFS_EVENT_ENA, 32'h1);
    for (int v = 1; v <= 5; v++) begin
      core.set_pm(3'(v % 5));
      repeat (2) @(posedge CLK_I);
      rc("power_mgmt_state", `POW_OFS_PM_STATUS, v % 5);
    end
    rc("event", `POW_OFS_EVENTS, 32'h1);
    rc("active", `POW_OFS_EVENT_ACT, 32'h1);
    cmp("irq", 32'h1, IRQ_O);
    wr(`POW_OFS_EVENTS, 32'h0);
    rc("event kept", `POW_OFS_EVENTS, 32'h1);
    wr(`POW_OFS_EVENTS, 32'h1);
    rc("event cleared", `POW_OFS_EVENTS, 32'h0);
    cmp("irq cleared", 32'h0, IRQ_O);
    wr(`POW_OFS_EVENT_ENA, 32'h0);
    core.set_pm(3'h2);
    repeat (4) @(posedge CLK_I);
    rc("masked event", `POW_OFS_EVENTS, 32'h1);
    rc("masked active", `POW_OFS_EVENT_ACT, 32'h0);
    cmp("masked irq", 32'h0, IRQ_O);
    // Wake polarity and drive style, request held apart from writes
    for (int c = 0; c < 4; c++) begin
      wr(`POW_OFS_WAKE_CFG, c << 1);
      @(posedge CLK_I);
      for (int q = 1; q >= 0; q--) begin
        WAKE_REQ_I <= q[0];
        @(posedge CLK_I);
        @(negedge CLK_I);
        e = q[0] ? c[1] : !c[1];
        cmp("wake level", e, WAKE_O);
        cmp("wake drive", q[0] | c[0], WAKE_OE_O);
        cmp("wake line", (q[0] | c[0]) ? e : 1'b1, wake_line);
        @(posedge CLK_I);
      end
    end
    BEACON_REQ_I <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      wr(`POW_OFS_WAKE_CFG, b);
      @(posedge CLK_I);
      @(negedge CLK_I);
      cmp("beacon", !b[0], BEACON_O);
      @(posedge CLK_I);
    end
    wrap_up();
  end
endmodule // test_pcie_outbound_window_wake_cfg
